// ===== hw/mdm_pkg.sv
package mdm_pkg;

  // ------------------------------------------------------------
  // Bus geometry
  // ------------------------------------------------------------
  localparam int MDM_ADDR_W = 32;
  localparam int MDM_DATA_W = 32;
  localparam int MDM_DIV_W  = 9;

  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [31:0] MDM_ADDR_CFG      = 32'h4405_0700;
  localparam logic [31:0] MDM_ADDR_CMD      = 32'h4405_0704;
  localparam logic [31:0] MDM_ADDR_DATA     = 32'h4405_0708;
  localparam logic [31:0] MDM_ADDR_IRQ_STAT = 32'h4405_070C;
  localparam logic [31:0] MDM_ADDR_IRQ_MASK = 32'h4405_0710;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int MDM_DIV_LSB    = 7;
  localparam int MDM_SUPP_BIT   = 5;
  localparam int MDM_HOLD_LSB   = 2;
  localparam int MDM_RNR_BIT    = 1;
  localparam int MDM_BUSY_BIT   = 0;
  localparam int MDM_LAUNCH_BIT = 15;
  localparam int MDM_PHY_LSB    = 5;
  localparam int MDM_REG_LSB    = 0;
  localparam int MDM_IRQ_DONE   = 1;
  localparam int MDM_IRQ_RERR   = 0;

  // ------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------
  localparam logic [8:0] MDM_DIV_RST  = 9'h028;
  localparam logic [2:0] MDM_HOLD_RST = 3'h0;
  localparam logic       MDM_SUPP_RST = 1'b0;

  // ------------------------------------------------------------
  // Frame layout and bit counts
  // ------------------------------------------------------------
  localparam logic [1:0]  MDM_SOF        = 2'h1;
  localparam logic [1:0]  MDM_OP_RD      = 2'h2;
  localparam logic [1:0]  MDM_OP_WR      = 2'h1;
  localparam logic [1:0]  MDM_TA_RD      = 2'h3;
  localparam logic [1:0]  MDM_TA_WR      = 2'h2;
  localparam logic [31:0] MDM_PREAMBLE   = 32'hFFFF_FFFF;
  localparam logic [6:0]  MDM_FRAME_BITS = 7'h20;
  localparam logic [6:0]  MDM_FULL_BITS  = 7'h40;
  localparam logic [6:0]  MDM_TA_FIRST   = 7'h12;
  localparam logic [6:0]  MDM_TA_LAST    = 7'h11;
  localparam logic [6:0]  MDM_DATA_LEFT  = 7'h10;

  typedef enum logic [1:0] {
    MDM_IDLE,
    MDM_WAIT_RISE,
    MDM_HOLD
  } mdm_state_t;

endpackage

// ===== hw/mdm_mdc_if.sv
`timescale 1ns/1ps
interface mdm_mdc_if;
  logic [mdm_pkg::MDM_DIV_W-1:0] divisor;
  logic                          mdc;
  logic                          mdc_rise;

  modport gen  (input divisor, output mdc, output mdc_rise);
  modport user (output divisor, input mdc, input mdc_rise);
endinterface

// ===== hw/mdm_sync2.sv
`timescale 1ns/1ps
module mdm_sync2 (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic meta;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta  <= 1'b1;
      q_out <= 1'b1;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule

// ===== hw/mdm_mdc_gen.sv
`timescale 1ns/1ps
module mdm_mdc_gen (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  mdm_mdc_if.gen    mdc_bus
);
  import mdm_pkg::*;

  logic [MDM_DIV_W:0] cnt;

  // Low phase d cycles, high phase d+1 cycles: period 2d+1
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt              <= '0;
      mdc_bus.mdc      <= 1'b0;
      mdc_bus.mdc_rise <= 1'b0;
    end else begin
      mdc_bus.mdc_rise <= 1'b0;
      if (mdc_bus.divisor == '0) begin
        cnt         <= '0;
        mdc_bus.mdc <= 1'b0;
      end else if (cnt <= 10'h001) begin
        mdc_bus.mdc      <= ~mdc_bus.mdc;
        mdc_bus.mdc_rise <= ~mdc_bus.mdc;
        cnt              <= mdc_bus.mdc ? {1'b0, mdc_bus.divisor}
                                        : 10'({1'b0, mdc_bus.divisor} + 10'h001);
      end else begin
        cnt <= 10'(cnt - 10'h001);
      end
    end
  end
endmodule

// ===== hw/mdm_top.sv
`timescale 1ns/1ps
module mdm_top (
  input  wire logic                           core_clk_in,
  input  wire logic                           arst_n_in,
  input  wire logic                           psel_in,
  input  wire logic                           penable_in,
  input  wire logic                           pwrite_in,
  input  wire logic [mdm_pkg::MDM_ADDR_W-1:0] paddr_in,
  input  wire logic [mdm_pkg::MDM_DATA_W-1:0] pwdata_in,
  output logic      [mdm_pkg::MDM_DATA_W-1:0] prdata_out,
  output logic                                pready_out,
  output logic                                pslverr_out,
  output logic                                mdc_out,
  input  wire logic                           mdio_in,
  output logic                                mdio_out,
  output logic                                mdio_oe_out,
  output logic                                irq_out
);
  import mdm_pkg::*;

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [8:0]  cfg_div;
  logic        cfg_supp;
  logic [2:0]  cfg_hold;
  logic [4:0]  cmd_phy;
  logic [4:0]  cmd_reg;
  logic [15:0] data_reg;
  logic        busy;
  logic        frame_rd;
  logic        read_no_response;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_mask;
  logic [1:0]  irq_set;
  logic [1:0]  irq_clr;
  logic        bus_wr;
  logic        bus_rd;
  logic        sel_cfg;
  logic        sel_cmd;
  logic        sel_data;
  logic        sel_stat;
  logic        sel_mask;
  logic        launch_rd;
  logic        launch_wr;
  logic        launch;
  logic        adv;
  logic        finish;
  logic [31:0] next_frame;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic [6:0]  next_left;
  mdm_state_t  state;
  logic [63:0] tx_sr;
  logic [6:0]  bits_left;
  logic [3:0]  hold_cnt;
  logic [15:0] rx_sr;
  logic        ta_bad;
  logic        mdio_sync;
  logic        mdc_rise;
  logic        bit_rise;
  logic        launch_q;

  mdm_mdc_if mdc_bus ();

  // ------------------------------------------------------------
  // Clock divider and input synchroniser
  // ------------------------------------------------------------
  assign mdc_bus.divisor = cfg_div;
  assign mdc_out         = mdc_bus.mdc;
  assign mdc_rise        = mdc_bus.mdc_rise;

  mdm_mdc_gen u_mdc_gen (
    .clk_in   (core_clk_in),
    .rst_n_in (rst_n),
    .mdc_bus  (mdc_bus.gen)
  );

  mdm_sync2 u_mdio_sync (
    .clk_in   (core_clk_in),
    .rst_n_in (rst_n),
    .d_in     (mdio_in),
    .q_out    (mdio_sync)
  );

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  assign pready_out = 1'b1;
  assign bus_wr     = psel_in & penable_in & pwrite_in;
  assign bus_rd     = psel_in & penable_in & ~pwrite_in;
  assign sel_cfg    = (paddr_in == MDM_ADDR_CFG);
  assign sel_cmd    = (paddr_in == MDM_ADDR_CMD);
  assign sel_data   = (paddr_in == MDM_ADDR_DATA);
  assign sel_stat   = (paddr_in == MDM_ADDR_IRQ_STAT);
  assign sel_mask   = (paddr_in == MDM_ADDR_IRQ_MASK);

  // Launches while busy are dropped so a running frame is never corrupted
  assign launch_rd = bus_wr & sel_cmd & pwdata_in[MDM_LAUNCH_BIT] & ~busy;
  assign launch_wr = bus_wr & sel_data & ~busy;
  assign launch    = launch_rd | launch_wr;

  // Read takes its addresses from the same write; write uses the stored ones
  always_comb begin
    if (launch_rd) begin
      next_frame = {MDM_SOF, MDM_OP_RD, pwdata_in[MDM_PHY_LSB +: 5],
                    pwdata_in[MDM_REG_LSB +: 5], MDM_TA_RD, 16'h0000};
    end else begin
      next_frame = {MDM_SOF, MDM_OP_WR, cmd_phy, cmd_reg, MDM_TA_WR,
                    pwdata_in[15:0]};
    end
  end

  // ------------------------------------------------------------
  // Configuration and command registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cfg_div  <= MDM_DIV_RST;
      cfg_supp <= MDM_SUPP_RST;
      cfg_hold <= MDM_HOLD_RST;
    end else if (bus_wr && sel_cfg) begin
      cfg_div  <= pwdata_in[MDM_DIV_LSB +: MDM_DIV_W];
      cfg_supp <= pwdata_in[MDM_SUPP_BIT];
      cfg_hold <= pwdata_in[MDM_HOLD_LSB +: 3];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cmd_phy <= 5'h00;
      cmd_reg <= 5'h00;
    end else if (bus_wr && sel_cmd) begin
      cmd_phy <= pwdata_in[MDM_PHY_LSB +: 5];
      cmd_reg <= pwdata_in[MDM_REG_LSB +: 5];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= 16'h0000;
    end else if (launch_wr) begin
      data_reg <= pwdata_in[15:0];
    end else if (finish && frame_rd) begin
      data_reg <= rx_sr;
    end
  end

  // ------------------------------------------------------------
  // Read data, captured in the setup phase
  // ------------------------------------------------------------
  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (sel_cfg) begin
      next_prdata[MDM_DIV_LSB +: MDM_DIV_W] = cfg_div;
      next_prdata[MDM_SUPP_BIT]             = cfg_supp;
      next_prdata[MDM_HOLD_LSB +: 3]        = cfg_hold;
      next_prdata[MDM_RNR_BIT]              = read_no_response;
      next_prdata[MDM_BUSY_BIT]             = busy;
    end else if (sel_cmd) begin
      next_prdata[MDM_LAUNCH_BIT]     = busy & frame_rd;
      next_prdata[MDM_PHY_LSB +: 5]   = cmd_phy;
      next_prdata[MDM_REG_LSB +: 5]   = cmd_reg;
    end else if (sel_data) begin
      next_prdata[15:0] = data_reg;
    end else if (sel_stat) begin
      next_prdata[1:0] = irq_stat;
    end else if (sel_mask) begin
      next_prdata[1:0] = irq_mask;
    end else begin
      next_pslverr = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (psel_in && !penable_in) begin
      prdata_out  <= pwrite_in ? 32'h0000_0000 : next_prdata;
      pslverr_out <= next_pslverr;
    end else if (!psel_in) begin
      pslverr_out <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Frame engine
  // ------------------------------------------------------------
  // A rise in the cycle right after a launch is skipped: the first bit needs a setup cycle
  assign bit_rise  = (state == MDM_WAIT_RISE) && mdc_rise && !launch_q;
  assign adv       = (bit_rise && cfg_hold == 3'h0) ||
                     ((state == MDM_HOLD) && (hold_cnt == 4'h0));
  assign finish    = adv && (bits_left == 7'h01);
  assign next_left = 7'(bits_left - 7'h01);

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      launch_q <= 1'b0;
    end else begin
      launch_q <= launch;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= MDM_IDLE;
    end else begin
      case (state)
        MDM_IDLE: begin
          if (launch) begin
            state <= MDM_WAIT_RISE;
          end
        end
        MDM_WAIT_RISE: begin
          if (finish) begin
            state <= MDM_IDLE;
          end else if (bit_rise && cfg_hold != 3'h0) begin
            state <= MDM_HOLD;
          end
        end
        MDM_HOLD: begin
          if (finish) begin
            state <= MDM_IDLE;
          end else if (adv) begin
            state <= MDM_WAIT_RISE;
          end
        end
        default: begin
          state <= MDM_IDLE;
        end
      endcase
    end
  end

  // With a nonzero hold code the bit changes only after the hold count; with hold code 0 it changes on the rising edge
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt <= 4'h0;
    end else if (bit_rise && cfg_hold != 3'h0) begin
      hold_cnt <= 4'({cfg_hold, 1'b0} - 4'h1);
    end else if (state == MDM_HOLD && hold_cnt != 4'h0) begin
      hold_cnt <= 4'(hold_cnt - 4'h1);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tx_sr       <= 64'h0000_0000_0000_0000;
      bits_left   <= 7'h00;
      mdio_out    <= 1'b0;
      mdio_oe_out <= 1'b0;
    end else if (launch) begin
      tx_sr       <= cfg_supp ? {next_frame, 32'h0000_0000}
                              : {MDM_PREAMBLE, next_frame};
      bits_left   <= cfg_supp ? MDM_FRAME_BITS : MDM_FULL_BITS;
      mdio_out    <= cfg_supp ? next_frame[31] : 1'b1;
      mdio_oe_out <= 1'b1;
    end else if (finish) begin
      bits_left   <= 7'h00;
      mdio_out    <= 1'b0;
      mdio_oe_out <= 1'b0;
    end else if (adv) begin
      tx_sr       <= {tx_sr[62:0], 1'b0};
      bits_left   <= next_left;
      mdio_out    <= tx_sr[62];
      // Pin released from the turnaround on so the PHY can answer
      mdio_oe_out <= !(frame_rd && next_left <= MDM_TA_FIRST);
    end
  end

  // Sampled pin lags two cycles; the half period is long enough to hide it
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_sr  <= 16'h0000;
      ta_bad <= 1'b0;
    end else if (bit_rise && frame_rd) begin
      if (bits_left == MDM_TA_LAST) begin
        ta_bad <= mdio_sync;
      end
      if (bits_left <= MDM_DATA_LEFT) begin
        rx_sr <= {rx_sr[14:0], mdio_sync};
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      busy     <= 1'b0;
      frame_rd <= 1'b0;
    end else if (launch) begin
      busy     <= 1'b1;
      frame_rd <= launch_rd;
    end else if (finish) begin
      busy     <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      read_no_response <= 1'b0;
    end else if (finish && frame_rd) begin
      read_no_response <= ta_bad;
    end
  end

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  assign irq_set[MDM_IRQ_DONE] = finish;
  assign irq_set[MDM_IRQ_RERR] = finish & frame_rd & ta_bad;

  // A read clears only what it returned, so later events survive
  always_comb begin
    irq_clr = 2'h0;
    if (bus_rd && sel_stat) begin
      irq_clr = prdata_out[1:0];
    end else if (bus_wr && sel_stat) begin
      irq_clr = pwdata_in[1:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= 2'h0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= 2'h0;
    end else if (bus_wr && sel_mask) begin
      irq_mask <= pwdata_in[1:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_stat & irq_mask);
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n);

  logic [10:0] since_rise;
  logic        per_ok;
  logic [8:0]  div_prev;

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      since_rise <= 11'h000;
      per_ok     <= 1'b0;
      div_prev   <= MDM_DIV_RST;
    end else begin
      div_prev <= cfg_div;
      if (mdc_rise) begin
        since_rise <= 11'h001;
      end else if (since_rise != 11'h7FF) begin
        since_rise <= 11'(since_rise + 11'h001);
      end
      if (cfg_div != div_prev || cfg_div == 9'h000) begin
        per_ok <= 1'b0;
      end else if (mdc_rise) begin
        per_ok <= 1'b1;
      end
    end
  end

  a_mdc_period: assert property (
    mdc_rise && per_ok && cfg_div == div_prev |-> since_rise == {1'b0, cfg_div, 1'b1})
    else $error("management clock period wrong");

  a_div_reset: assert property ($rose(rst_n) |-> cfg_div == 9'h028)
    else $error("divisor not 40 after reset");

  a_mdc_stopped: assert property (
    cfg_div == 9'h000 && $past(cfg_div) == 9'h000 |=> !mdc_out && !mdc_rise)
    else $error("clock toggles with divisor zero");

  a_preamble_sent: assert property (
    launch && !cfg_supp |=> bits_left == 7'h40 && mdio_out && mdio_oe_out)
    else $error("preamble missing");

  a_preamble_off: assert property (
    launch && cfg_supp |=> bits_left == 7'h20 && !mdio_out && mdio_oe_out)
    else $error("suppressed frame does not open with start");

  a_start_bits: assert property (
    adv && bits_left == 7'h20 |=> mdio_out)
    else $error("start pattern wrong");

  a_hold_time: assert property (
    adv && cfg_div > 9'h007 |->
      (mdc_rise ? cfg_hold == 3'h0 : since_rise == {7'h00, cfg_hold, 1'b0}))
    else $error("hold time wrong");

  a_read_error: assert property (
    finish && frame_rd |=> read_no_response == $past(ta_bad))
    else $error("read error flag wrong");

  a_busy_write: assert property (
    launch_wr |=> busy ##0 (busy throughout (state != MDM_IDLE)[*2]))
    else $error("busy not raised after data write");

  a_busy_end: assert property (finish |=> !busy && !mdio_oe_out)
    else $error("busy stays after frame end");

  a_read_release: assert property (
    busy && frame_rd && bits_left <= 7'h12 && !launch |-> !mdio_oe_out)
    else $error("pin driven during read answer");

  a_read_data: assert property (
    finish && frame_rd |=> data_reg == $past(rx_sr))
    else $error("read data not returned");

  a_reserved_zero: assert property (
    bus_rd |-> prdata_out[31:16] == 16'h0000)
    else $error("reserved bits not zero");

  a_done_latch: assert property (
    finish |=> irq_stat[1] ##1 irq_out == irq_mask[1] || !irq_stat[1])
    else $error("completion latch not set");

  c_read_done:   cover property (finish && frame_rd && !ta_bad);
  c_read_error:  cover property (finish && frame_rd && ta_bad);
  c_write_done:  cover property (finish && !frame_rd);
  c_short_frame: cover property (launch && cfg_supp);
endmodule

// ===== testbench/mdm_phy_model.sv
`timescale 1ns/1ps
module mdm_phy_model #(
  parameter logic [4:0] PHY_ADDR = 5'h03
) (
  input  wire logic        mdc_in,
  input  wire logic        mdio_in,
  output logic             drive_out,
  output logic             data_out,
  output logic [15:0]      wr_data_out
);
  logic [15:0] regs [32];
  logic [11:0] hdr;
  logic [15:0] sh;
  logic        prev;
  logic        answer;
  int          cnt;

  initial begin
    for (int i = 0; i < 32; i++) regs[i] = 16'h5A00 | 16'(i);
    cnt = 0;
    prev = 1'b1;
    answer = 1'b0;
    drive_out = 1'b0;
    data_out = 1'b1;
    wr_data_out = 16'h0000;
  end

  // ------------------------------------------------------------
  // Sample on the rising management clock
  // ------------------------------------------------------------
  always @(posedge mdc_in) begin
    if (cnt == 0) begin
      if (!prev && mdio_in) cnt = 2;
      prev = mdio_in;
    end else begin
      if (cnt < 14) hdr = {hdr[10:0], mdio_in};
      if (cnt >= 16) sh = {sh[14:0], mdio_in};
      if (cnt == 13) answer = (hdr[11:10] == 2'b10) && (hdr[9:5] == PHY_ADDR);
      if (cnt == 31 && hdr[11:10] == 2'b01 && hdr[9:5] == PHY_ADDR) begin
        regs[hdr[4:0]] = sh;
        wr_data_out = sh;
      end
      cnt++;
    end
  end

  // ------------------------------------------------------------
  // Drive after the fall, clear of the sampling rise
  // ------------------------------------------------------------
  always @(negedge mdc_in) begin
    drive_out = answer && cnt >= 15 && cnt <= 31;
    data_out = (cnt >= 16 && cnt <= 31) ? regs[hdr[4:0]][31-cnt] : 1'b0;
    if (cnt == 32) begin
      cnt = 0;
      prev = 1'b1;
      answer = 1'b0;
    end
  end
endmodule

// ===== testbench/test_mdio_management_master.sv
`timescale 1ns/1ps
module test_mdio_management_master;
  import mdm_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, q;
  logic        mdc, mdio_in, mdio_o, mdio_oe, irq, phy_drv, phy_d, e;
  logic        mdc_q, mdio_q, oe_q;
  logic [15:0] phy_wr;
  int          errors, total_checks, rises, since, period, hold_seen, tg, snap;

  // Tri-state line with pull-up
  assign mdio_in = mdio_oe ? mdio_o : (phy_drv ? phy_d : 1'b1);

  mdm_top i_dut (.core_clk_in(clk), .arst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .mdc_out(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_o), .mdio_oe_out(mdio_oe), .irq_out(irq));
  mdm_phy_model i_phy (.mdc_in(mdc), .mdio_in(mdio_in), .drive_out(phy_drv),
    .data_out(phy_d), .wr_data_out(phy_wr));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Link monitor: period, hold and rise counts
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (mdc !== mdc_q) tg++;
    if (mdc && !mdc_q) begin
      if (mdio_oe && oe_q) rises++;
      period = since;
      since = 1;
    end else begin
      if (mdio_oe && mdio_o !== mdio_q) hold_seen = since;
      since++;
    end
    mdc_q = mdc;
    mdio_q = mdio_o;
    oe_q = mdio_oe;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Answer taken at the edge where pready is seen high
    while (1) begin
      @(posedge clk);
      n++;
      if (pready === 1'b1) break;
      if (n > 50) begin
        errors++;
        summarize();
      end
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    q = 32'h0000_0001;
    while (q[0] !== 1'b0) begin
      apb(1'b0, MDM_ADDR_CFG, 32'h0000_0000);
      n++;
      if (n > 3000) begin
        errors++;
        summarize();
      end
    end
  endtask

  initial begin
    errors = 0; total_checks = 0; rises = 0; since = 0; period = 0; hold_seen = 0; tg = 0;
    mdc_q = 1'b0; mdio_q = 1'b0; oe_q = 1'b0;
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 32'h0000_0000; pwdata = 32'h0000_0000;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, MDM_ADDR_CFG, 32'h0000_0000);
    chk("cfg reset", q, 32'h0000_1400);
    apb(1'b0, 32'h4405_0720, 32'h0000_0000);
    chk("unmapped err", {31'h0, e}, 32'h0000_0001);
    // Write frame with preamble, hold code 1, divisor 8
    apb(1'b1, MDM_ADDR_CFG, 32'hFFFF_0447);
    apb(1'b0, MDM_ADDR_CFG, 32'h0000_0000);
    chk("cfg reserved", q, 32'h0000_0404);
    apb(1'b1, MDM_ADDR_IRQ_MASK, 32'h0000_0002);
    apb(1'b1, MDM_ADDR_CMD, 32'h0000_0065);
    rises = 0;
    apb(1'b1, MDM_ADDR_DATA, 32'hFFFF_1234);
    apb(1'b0, MDM_ADDR_CFG, 32'h0000_0000);
    chk("busy after write", q, 32'h0000_0405);
    wait_idle();
    chk("phy data", {16'h0, phy_wr}, 32'h0000_1234);
    chk("rises preamble", rises, 64);
    chk("hold k1", hold_seen, 3);
    chk("period d8", period, 17);
    chk("irq done", {31'h0, irq}, 32'h0000_0001);
    apb(1'b0, MDM_ADDR_IRQ_STAT, 32'h0000_0000);
    chk("stat done", q, 32'h0000_0002);
    // Read frame, suppressed preamble, hold code 7
    apb(1'b1, MDM_ADDR_CFG, 32'h0000_043C);
    rises = 0;
    apb(1'b1, MDM_ADDR_CMD, 32'h0000_8067);
    wait_idle();
    chk("cfg after read", q, 32'h0000_043C);
    apb(1'b0, MDM_ADDR_DATA, 32'h0000_0000);
    chk("read data", q, 32'h0000_5A07);
    chk("rises suppressed", rises, 14);
    chk("hold k7", hold_seen, 15);
    // No answer from an absent PHY, interrupt masked
    apb(1'b1, MDM_ADDR_IRQ_MASK, 32'h0000_0000);
    apb(1'b0, MDM_ADDR_IRQ_STAT, 32'h0000_0000);
    apb(1'b1, MDM_ADDR_CMD, 32'h0000_8127);
    wait_idle();
    chk("read error", q, 32'h0000_043E);
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    apb(1'b1, MDM_ADDR_IRQ_MASK, 32'h0000_0003);
    repeat (3) @(posedge clk);
    chk("irq unmasked", {31'h0, irq}, 32'h0000_0001);
    apb(1'b0, MDM_ADDR_IRQ_STAT, 32'h0000_0000);
    chk("stat both", q, 32'h0000_0003);
    repeat (3) @(posedge clk);
    chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
    // Divisor 5, then a stopped clock
    apb(1'b1, MDM_ADDR_CFG, 32'h0000_0280);
    repeat (40) @(posedge clk);
    chk("period d5", period, 11);
    apb(1'b1, MDM_ADDR_CFG, 32'h0000_0000);
    repeat (20) @(posedge clk);
    snap = tg;
    repeat (200) @(posedge clk);
    chk("mdc stopped", tg - snap, 0);
    summarize();
  end
endmodule
